// ==== logic/sdcfg_pkg.sv ====
// Purpose: constants for the SDRAM configuration register group
// Assumes: 32-bit register port, byte offsets
// Notes: widths and encodings are fixed
package sdcfg_pkg;
    // ****************************************
    // Offsets
    // ****************************************
    localparam logic [11:0] OFF_MEMORY_LAYOUT_CONFIG = 12'h00C;
    localparam logic [11:0] OFF_REFRESH_INTERVAL_SETTING = 12'h010;
    localparam logic [11:0] OFF_READ_LATENCY_SETTING = 12'h014;
    localparam logic [11:0] OFF_WRITE_STROBE_DELAY_SETTING = 12'h018;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_CHIPS_HI = 22;
    localparam int CFG_CHIPS_LO = 21;
    localparam int CFG_BURST_HI = 17;
    localparam int CFG_BURST_LO = 15;
    localparam int CFG_CLKSTOP = 14;
    localparam int CFG_PDOWN_EN = 13;
    localparam int CFG_IDLE_HI = 12;
    localparam int CFG_IDLE_LO = 7;
    localparam int CFG_AP_POS = 6;
    localparam int CFG_ROW_HI = 5;
    localparam int CFG_ROW_LO = 3;
    localparam int CFG_COL_HI = 2;
    localparam int CFG_COL_LO = 0;
    localparam int REF_HI = 14;
    localparam int CAS_HI = 3;
    localparam int CAS_LO = 1;
    localparam int DQSS_HI = 1;
    // Writable masks; other bits read zero
    localparam logic [31:0] CFG_MASK = 32'h0067FFFF;
    localparam logic [31:0] REF_MASK = 32'h00007FFF;
    localparam logic [31:0] CAS_MASK = 32'h0000000E;
    localparam logic [31:0] DQSS_MASK = 32'h00000003;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] CFG_RESET = 32'h00010080;
    localparam logic [31:0] REF_RESET = 32'h00000A60;
    localparam logic [31:0] CAS_RESET = 32'h00000006;
    localparam logic [31:0] DQSS_RESET = 32'h00000001;
    // ****************************************
    // Controller state codes
    // ****************************************
    localparam logic [1:0] ST_CONFIG = 2'h0;
    localparam logic [1:0] ST_READY = 2'h1;
    localparam logic [1:0] ST_PAUSED = 2'h2;
    localparam logic [1:0] ST_LOW_POWER = 2'h3;
    // Refresh sequencer states
    typedef enum logic [2:0] {
        SDCFG_RF_COUNT = 3'b001,
        SDCFG_RF_ISSUE = 3'b010,
        SDCFG_RF_NEXT = 3'b100
    } sdcfg_rf_e;
endpackage

// ==== logic/sdcfg_idle_timer.sv ====
// Purpose: idle counter that flags power-down after a programmed wait
// Assumes: clk_sys domain, period held stable while enabled
// Notes: any activity restarts the count
`timescale 1ns/1ps
module sdcfg_idle_timer import sdcfg_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic enable,
    input wire logic busy,
    input wire logic [5:0] period,
    // Result
    output logic expired
);
    logic [5:0] count_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_r <= 6'h00;
            expired <= 1'b0;
        end else if (!enable || busy) begin
            count_r <= 6'h00;
            expired <= 1'b0;
        end else if (count_r >= period && period != 6'h00) begin
            expired <= 1'b1;
        end else begin
            count_r <= count_r + 6'h01;
        end
    end
endmodule // sdcfg_idle_timer

// ==== logic/sdcfg_regs.sv ====
// Purpose: SDRAM configuration register group with refresh and power controls
// Assumes: single-cycle register port, memory clock equals clk_sys
// Notes: access gated by controller state
//
// What this block does
// - Config registers accessed only in Config or Low-power state.
// - Bits 22:21 pick one to four chips for refresh.
// - Refresh never addresses more chips than implemented count.
// - Bits 17:15 set burst length 1, 2, 4, 8 or 16.
// - Bit 14 stops memory clock while no access runs and no refresh is pending.
// - Bit 13 drops CKE after idle period with empty FIFO, unless a refresh is pending.
// - Bits 12:7 give idle wait cycles, at least one.
// - Bit 6 puts auto-precharge flag on address 10 or 8.
// - Bits 5:3 give row width 11 to 16 bits.
// - Bits 2:0 give column width 8 to 12 bits.
// - Refresh interval bits 14:0 in memory cycles; upper bits unused.
// - CAS latency bits 3:1; bit 0 reserved.
// - Write strobe delay in bits 1:0; rest unused.
// - Reserved bits read undefined here zero, except config bit 18, which reads back as written; software writes zeros.
// - Two-bit state: Config, Ready, Paused, Low-power gates access.
// - Implemented chip count limits refresh chip count.
`timescale 1ns/1ps
module sdcfg_regs import sdcfg_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // Controller status
    input wire logic [1:0] ctrl_state,
    input wire logic [1:0] chips_implemented,
    input wire logic access_busy,
    input wire logic cmd_fifo_empty,
    input wire logic refresh_done,
    // Memory control outputs
    output logic mem_clk_en,
    output logic mem_cke,
    output logic refresh_req,
    output logic [1:0] refresh_chip,
    output logic [4:0] burst_beats,
    output logic [3:0] ap_addr_bit,
    output logic [4:0] row_addr_bits,
    output logic [3:0] col_addr_bits,
    output logic [2:0] cas_cycles,
    output logic [1:0] dqss_cycles
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [31:0] cfg_r;
    logic [31:0] ref_r;
    logic [31:0] cas_r;
    logic [31:0] dqss_r;
    logic access_ok;
    logic wr_en;
    logic [31:0] rdata_nxt;

    assign access_ok = (ctrl_state == ST_CONFIG) || (ctrl_state == ST_LOW_POWER);
    assign wr_en = reg_sel && reg_write && access_ok;

    // Writes land only in a legal state; others leave settings intact
    // reserved masked
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_r <= CFG_RESET;
        end else if (wr_en && reg_addr == OFF_MEMORY_LAYOUT_CONFIG) begin
            cfg_r <= reg_wdata & CFG_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_r <= REF_RESET;
        end else if (wr_en && reg_addr == OFF_REFRESH_INTERVAL_SETTING) begin
            ref_r <= reg_wdata & REF_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cas_r <= CAS_RESET;
        end else if (wr_en && reg_addr == OFF_READ_LATENCY_SETTING) begin
            cas_r <= reg_wdata & CAS_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dqss_r <= DQSS_RESET;
        end else if (wr_en && reg_addr == OFF_WRITE_STROBE_DELAY_SETTING) begin
            dqss_r <= reg_wdata & DQSS_MASK;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (reg_sel && !reg_write && access_ok) begin
            case (reg_addr)
                OFF_MEMORY_LAYOUT_CONFIG: rdata_nxt = cfg_r;
                OFF_REFRESH_INTERVAL_SETTING: rdata_nxt = ref_r;
                OFF_READ_LATENCY_SETTING: rdata_nxt = cas_r;
                OFF_WRITE_STROBE_DELAY_SETTING: rdata_nxt = dqss_r;
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Refused accesses still answered, so the port never stalls
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_sel;
        end
    end

    // ****************************************
    // Decoded geometry and timing
    // ****************************************
    // Decodes lag the register one cycle; users never see a glitch
    // burst decode
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            burst_beats <= 5'h04;
        end else begin
            // Reserved codes fall back to single beats
            case (cfg_r[CFG_BURST_HI:CFG_BURST_LO])
                3'h0: burst_beats <= 5'h01;
                3'h1: burst_beats <= 5'h02;
                3'h2: burst_beats <= 5'h04;
                3'h3: burst_beats <= 5'h08;
                3'h4: burst_beats <= 5'h10;
                default: burst_beats <= 5'h01;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ap_addr_bit <= 4'hA;
        end else begin
            ap_addr_bit <= cfg_r[CFG_AP_POS] ? 4'h8 : 4'hA;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            row_addr_bits <= 5'h0B;
        end else begin
            row_addr_bits <= 5'h0B + {2'h0, cfg_r[CFG_ROW_HI:CFG_ROW_LO]};
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            col_addr_bits <= 4'h8;
        end else begin
            col_addr_bits <= 4'h8 + {1'b0, cfg_r[CFG_COL_HI:CFG_COL_LO]};
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cas_cycles <= 3'h3;
        end else begin
            cas_cycles <= cas_r[CAS_HI:CAS_LO];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dqss_cycles <= 2'h1;
        end else begin
            dqss_cycles <= dqss_r[DQSS_HI:0];
        end
    end

    // ****************************************
    // Clock stop and power-down
    // ****************************************
    logic idle_expired;

    sdcfg_idle_timer u_idle (
        .clk_sys(clk_sys),
        .reset(reset),
        .enable(cfg_r[CFG_PDOWN_EN]),
        .busy(!cmd_fifo_empty || access_busy),
        .period(cfg_r[CFG_IDLE_HI:CFG_IDLE_LO]),
        .expired(idle_expired)
    );

    // gate idle clock; refresh needs clock too
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_clk_en <= 1'b1;
        end else begin
            mem_clk_en <= !cfg_r[CFG_CLKSTOP] || access_busy || refresh_req;
        end
    end

    // drop CKE
    // A pending refresh wakes the chips; they cannot refresh asleep
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_cke <= 1'b1;
        end else begin
            mem_cke <= !idle_expired || refresh_req;
        end
    end

    // ****************************************
    // Refresh sequencer
    // ****************************************
    sdcfg_rf_e rf_r;
    logic [14:0] rf_count_r;
    logic [1:0] chip_limit;
    logic [1:0] chip_last;

    assign chip_limit = cfg_r[CFG_CHIPS_HI:CFG_CHIPS_LO];
    // Clamp guards against a count the controller cannot drive
    assign chip_last = (chip_limit > chips_implemented) ? chips_implemented : chip_limit;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rf_r <= SDCFG_RF_COUNT;
            rf_count_r <= 15'h0000;
            refresh_req <= 1'b0;
            refresh_chip <= 2'h0;
        end else begin
            case (rf_r)
                SDCFG_RF_COUNT: begin
                    // Held in Config so a half-built setup never refreshes
                    if (ref_r[REF_HI:0] == 15'h0000 || ctrl_state == ST_CONFIG) begin
                        rf_count_r <= 15'h0000;
                    end else if (rf_count_r + 15'h0001 >= ref_r[REF_HI:0]) begin
                        rf_count_r <= 15'h0000;
                        refresh_chip <= 2'h0;
                        refresh_req <= 1'b1;
                        rf_r <= SDCFG_RF_ISSUE;
                    end else begin
                        rf_count_r <= rf_count_r + 15'h0001;
                    end
                end
                SDCFG_RF_ISSUE: begin
                    if (refresh_done) begin
                        refresh_req <= 1'b0;
                        rf_r <= SDCFG_RF_NEXT;
                    end
                end
                SDCFG_RF_NEXT: begin
                    if (refresh_chip >= chip_last) begin
                        rf_r <= SDCFG_RF_COUNT;
                    end else begin
                        refresh_chip <= refresh_chip + 2'h1;
                        refresh_req <= 1'b1;
                        rf_r <= SDCFG_RF_ISSUE;
                    end
                end
                default: begin
                    rf_r <= SDCFG_RF_COUNT;
                    refresh_req <= 1'b0;
                end
            endcase
        end
    end
endmodule // sdcfg_regs

// ==== test/sdcfg_chk.sv ====
// Purpose: port checker for the SDRAM configuration registers
// Assumes: one clock, asynchronous active-high reset
// Notes: attached by bind at the foot
`timescale 1ns/1ps
module sdcfg_chk import sdcfg_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    // Status and memory side
    input wire logic [1:0] ctrl_state,
    input wire logic [1:0] chips_implemented,
    input wire logic access_busy,
    input wire logic cmd_fifo_empty,
    input wire logic refresh_done,
    input wire logic mem_clk_en,
    input wire logic mem_cke,
    input wire logic refresh_req,
    input wire logic [1:0] refresh_chip,
    input wire logic [4:0] burst_beats,
    input wire logic [3:0] ap_addr_bit,
    input wire logic [4:0] row_addr_bits,
    input wire logic [3:0] col_addr_bits
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Legal layout write only; reserved encodings have no defined decode
    wire cfg_wr = reg_sel && reg_write && reg_addr == OFF_MEMORY_LAYOUT_CONFIG
        && (ctrl_state == ST_CONFIG || ctrl_state == ST_LOW_POWER)
        && reg_wdata[17:15] <= 3'h4 && reg_wdata[5:3] <= 3'h5 && reg_wdata[2:0] <= 3'h4;
    ack_after_sel_a: assert property (reg_sel |=> reg_ack)
        else $error("access not acknowledged");
    ack_needs_sel_a: assert property (reg_ack |-> $past(reg_sel))
        else $error("acknowledge without access");
    blocked_read_a: assert property (reg_sel && !reg_write
        && (ctrl_state == ST_READY || ctrl_state == ST_PAUSED) |=> reg_rdata == 32'h0)
        else $error("blocked read returned data");
    burst_decode_a: assert property (cfg_wr |->
        ##2 burst_beats == (5'h01 << $past(reg_wdata[17:15], 2)))
        else $error("burst length decode wrong");
    ap_decode_a: assert property (cfg_wr |->
        ##2 ap_addr_bit == ($past(reg_wdata[6], 2) ? 4'h8 : 4'hA))
        else $error("auto-precharge position wrong");
    row_decode_a: assert property (cfg_wr |->
        ##2 row_addr_bits == 5'h0B + {2'h0, $past(reg_wdata[5:3], 2)})
        else $error("row width decode wrong");
    col_decode_a: assert property (cfg_wr |->
        ##2 col_addr_bits == 4'h8 + {1'h0, $past(reg_wdata[2:0], 2)})
        else $error("column width decode wrong");
    chip_limit_a: assert property (refresh_req |-> refresh_chip <= chips_implemented)
        else $error("refresh beyond implemented chips");
    req_hold_a: assert property (refresh_req && !refresh_done |=> refresh_req)
        else $error("refresh request dropped early");
    cke_wake_a: assert property (!cmd_fifo_empty || access_busy |-> ##[0:2] mem_cke)
        else $error("power-down kept during activity");
    clk_run_a: assert property (access_busy |-> ##[0:2] mem_clk_en)
        else $error("memory clock stopped during access");
    cover property (cfg_wr);
    cover property ($fell(mem_cke));
    cover property ($fell(mem_clk_en));
    cover property (refresh_req && refresh_chip == 2'h2);
endmodule // sdcfg_chk
bind sdcfg_regs sdcfg_chk sdcfg_chk_i (.*);

// ==== test/sdcfg_mem_model.sv ====
// Purpose: far-side SDRAM chips answering refresh requests
// Assumes: answer delay set by the bench
// Notes: records which chips were refreshed
`timescale 1ns/1ps
module sdcfg_mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Refresh handshake
    input wire logic refresh_req,
    input wire logic [1:0] refresh_chip,
    output logic refresh_done,
    // Bench control
    input wire logic [3:0] delay,
    input wire logic clear,
    output logic [3:0] chips_hit
);
    logic [3:0] wait_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            refresh_done <= 1'b0;
            wait_r <= 4'h0;
        end else if (refresh_done || !refresh_req) begin
            refresh_done <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r == delay) begin
            refresh_done <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset || clear) begin
            chips_hit <= 4'h0;
        end else if (refresh_done && refresh_req) begin
            chips_hit[refresh_chip] <= 1'b1;
        end
    end
endmodule // sdcfg_mem_model

// ==== test/test_sdcfg_regs.sv ====
// Purpose: self-checking bench for the SDRAM configuration registers
// Assumes: inputs driven on the falling edge
// Notes: chip model answers refreshes
`timescale 1ns/1ps
module test_sdcfg_regs import sdcfg_pkg::*; ;
    logic clk_sys = 1'b0, reset = 1'b1, reg_sel = 1'b0, reg_write = 1'b0, reg_ack;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [1:0] ctrl_state = ST_CONFIG, chips_implemented = 2'h3, refresh_chip, dqss_cycles;
    logic access_busy = 1'b0, cmd_fifo_empty = 1'b0, refresh_done, clear = 1'b0;
    logic mem_clk_en, mem_cke, refresh_req;
    logic [3:0] ap_addr_bit, col_addr_bits, delay = 4'h0, chips_hit;
    logic [4:0] burst_beats, row_addr_bits;
    logic [2:0] cas_cycles;
    int failures = 0, total_checks = 0;
    sdcfg_regs sdcfg_regs_i (.*);
    sdcfg_mem_model sdcfg_mem_model_i (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic summarize;
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            failures++;
            $display("Error wait bound expected %0d seen %0d", lim - 1, i);
            summarize();
        end
    endtask
    // One access; returns after the decodes have settled
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        reg_sel = 1'b1;
        reg_write = w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_sel = 1'b0;
        rd = reg_rdata;
        chk("ack", 32'h1, {31'h0, reg_ack});
        @(negedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        acc(1'b1, a, d, x);
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        acc(1'b0, a, 32'h0, x);
        chk(n, e, x);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_masks;
        logic [11:0] offs [4] = '{OFF_MEMORY_LAYOUT_CONFIG, OFF_REFRESH_INTERVAL_SETTING,
                                  OFF_READ_LATENCY_SETTING, OFF_WRITE_STROBE_DELAY_SETTING};
        logic [31:0] rst [4] = '{CFG_RESET, REF_RESET, CAS_RESET, DQSS_RESET};
        logic [31:0] msk [4] = '{CFG_MASK, REF_MASK, CAS_MASK, DQSS_MASK};
        for (int i = 0; i < 4; i++) begin
            rdc("reset value", offs[i], rst[i]);
            wr(offs[i], 32'hFFFFFFFF);
            rdc("masked", offs[i], msk[i]);
        end
        chk("cas", 32'h7, {29'h0, cas_cycles});
        chk("dqss", 32'h3, {30'h0, dqss_cycles});
        wr(12'h01C, 32'h5);
        rdc("unmapped", 12'h01C, 32'h0);
    endtask
    task automatic t_gate;
        ctrl_state = ST_READY;
        wr(OFF_REFRESH_INTERVAL_SETTING, 32'h123);
        rdc("ready read", OFF_REFRESH_INTERVAL_SETTING, 32'h0);
        ctrl_state = ST_PAUSED;
        rdc("paused read", OFF_REFRESH_INTERVAL_SETTING, 32'h0);
        ctrl_state = ST_LOW_POWER;
        rdc("kept", OFF_REFRESH_INTERVAL_SETTING, 32'h7FFF);
        wr(OFF_REFRESH_INTERVAL_SETTING, 32'h55);
        rdc("low power", OFF_REFRESH_INTERVAL_SETTING, 32'h55);
        ctrl_state = ST_CONFIG;
    endtask
    task automatic t_decode;
        for (int c = 0; c < 6; c++) begin
            wr(OFF_MEMORY_LAYOUT_CONFIG, {14'h0, 3'(c % 5), 8'h0, 1'(c), 3'(c), 3'(c % 5)});
            chk("burst", 32'h1 << (c % 5), {27'h0, burst_beats});
            chk("ap", (c % 2) ? 32'h8 : 32'hA, {28'h0, ap_addr_bit});
            chk("row", 32'hB + 32'(c), {27'h0, row_addr_bits});
            chk("col", 32'h8 + 32'(c % 5), {28'h0, col_addr_bits});
        end
    endtask
    task automatic t_refresh(input logic [1:0] impl, input logic [1:0] act,
                             input logic [3:0] dl, input logic [3:0] e);
        int i;
        chips_implemented = impl;
        delay = dl;
        wr(OFF_MEMORY_LAYOUT_CONFIG, {9'h0, act, 21'h0});
        wr(OFF_REFRESH_INTERVAL_SETTING, 32'h14);
        clear = 1'b1;
        @(negedge clk_sys);
        clear = 1'b0;
        ctrl_state = ST_READY;
        for (i = 0; i < 400 && chips_hit !== e; i++) @(negedge clk_sys);
        bound(i, 400);
        repeat (10) @(negedge clk_sys);
        chk("chips", {28'h0, e}, {28'h0, chips_hit});
        ctrl_state = ST_CONFIG;
        wr(OFF_REFRESH_INTERVAL_SETTING, 32'h0);
    endtask
    task automatic t_idle;
        int i;
        wr(OFF_MEMORY_LAYOUT_CONFIG, {17'h0, 1'b1, 1'b1, 6'h3, 7'h0});
        cmd_fifo_empty = 1'b1;
        for (i = 0; i < 20 && mem_cke !== 1'b0; i++) @(negedge clk_sys);
        bound(i, 20);
        chk("idle wait", 32'h1, {31'h0, i >= 3});
        cmd_fifo_empty = 1'b0;
        for (i = 0; i < 3 && mem_cke !== 1'b1; i++) @(negedge clk_sys);
        bound(i, 3);
        for (i = 0; i < 5 && mem_clk_en !== 1'b0; i++) @(negedge clk_sys);
        bound(i, 5);
        access_busy = 1'b1;
        for (i = 0; i < 3 && mem_clk_en !== 1'b1; i++) @(negedge clk_sys);
        bound(i, 3);
        access_busy = 1'b0;
        for (i = 0; i < 3 && mem_clk_en !== 1'b0; i++) @(negedge clk_sys);
        bound(i, 3);
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        t_masks;
        t_gate;
        t_decode;
        t_refresh(2'h1, 2'h3, 4'h0, 4'h3);
        t_refresh(2'h3, 2'h2, 4'h5, 4'h7);
        t_idle;
        summarize;
    end
endmodule // test_sdcfg_regs
